// >>> design/kbm_pkg.sv
// Constants of the keyboard-controller host mailbox.
// Assumes the host decodes a 16-bit I/O address and the core a port word.
package kbm_pkg;

	// ----------------------------------------
	// Host I/O addresses
	// ----------------------------------------
	localparam logic [15:0] DATA_PORT_ADDR = 16'h0060;
	localparam logic [15:0] CTL_PORT_ADDR = 16'h0064;
	localparam int HOST_ADDR_CD_BIT = 2;

	// ----------------------------------------
	// Status register layout
	// ----------------------------------------
	localparam int ST_OBF_BIT = 0;
	localparam int ST_IBF_BIT = 1;
	localparam int ST_CD_BIT = 3;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] STATUS_UD_MASK = 8'hf4;

	// ----------------------------------------
	// Core output port bit positions
	// ----------------------------------------
	localparam int PB_A20 = 1;
	localparam int PB_MOUSE_DATA = 2;
	localparam int PB_MOUSE_CLOCK = 3;
	localparam int PB_KB_IRQ = 4;
	localparam int PB_MOUSE_IRQ = 5;
	localparam int PB_KB_CLOCK = 6;
	localparam int PB_KB_DATA = 7;
	// Pin bits at one so that all four pins are pulled low out of reset
	localparam logic [7:0] PORT_RESET = 8'hcc;

	// ----------------------------------------
	// Reset pulse length expected of the system
	// ----------------------------------------
	localparam int REF_CLK_HZ = 16000000;
	localparam int RESET_REF_PERIODS = 24;
	localparam int SYS_CLK_HZ = 250000000;
	localparam int RESET_MIN_NS = (RESET_REF_PERIODS * 1000) / 16;
	localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * (SYS_CLK_HZ / 1000000)
		+ 999) / 1000;

	// ----------------------------------------
	// Core power state
	// ----------------------------------------
	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_SOFT_DOWN = 2'b01,
		PWR_HARD_DOWN = 2'b10
	} kbm_pwr_t;

endpackage

// >>> design/kbm_sync.sv
// Two-flop synchroniser for pin levels.
// Assumes inputs are asynchronous to clk_sys; width set per instance.
`timescale 1ns/10ps
`default_nettype none
module kbm_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;

	generate
		if (WIDTH < 1) begin : g_chk
			$error("kbm_sync needs WIDTH of at least one");
		end
	endgenerate

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stage1_q <= RESET_VAL;
			stage2_q <= RESET_VAL;
		end else begin
			stage1_q <= asyncIn;
			stage2_q <= stage1_q;
		end
	end

	assign syncOut = stage2_q;

endmodule
`default_nettype wire

// >>> design/kbm_host_mailbox.sv
// Host mailbox of the keyboard controller: buffers, status, IRQs, pins.
// Assumes host and core strobes are one-cycle pulses on clk_sys and
// that the four keyboard/mouse pins resolve open-drain outside.
`timescale 1ns/10ps
`default_nettype none
module kbm_host_mailbox #(
	parameter int HOST_ADDR_W = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	// Host I/O side
	input wire logic hostWrStb,
	input wire logic hostRdStb,
	input wire logic [HOST_ADDR_W-1:0] hostAddr,
	input wire logic [7:0] hostWrData,
	output logic [7:0] hostRdData,
	output logic hostRdValid,
	output logic keyboard_irq_out,
	output logic mouse_irq_out,
	// Core side
	input wire logic coreIbRdStb,
	input wire logic coreObWrStb,
	input wire logic [7:0] coreObWrData,
	input wire logic coreStatusWrStb,
	input wire logic [7:0] coreStatusWrData,
	input wire logic corePortWrStb,
	input wire logic [7:0] corePortWrData,
	input wire logic coreEnFlagsStb,
	input wire logic coreHaltStb,
	input wire logic coreStopStb,
	input wire logic coreIbfIrqEn,
	input wire logic coreTimerOvf,
	output logic [7:0] core_input_buffer,
	output logic [7:0] coreStatus,
	output logic coreIbfIrq,
	output logic coreTimerIrq,
	output logic coreAluClkEn,
	output logic coreOscEn,
	output logic coreWakeCall,
	output logic coreWakeNext,
	output logic a20_gate_out,
	// Open-drain pins and their readback
	input wire logic kbClockPinIn,
	input wire logic kbDataPinIn,
	input wire logic mouseClockPinIn,
	input wire logic mouseDataPinIn,
	output logic kbClockPinOut,
	output logic kbClockPinOe,
	output logic kbDataPinOut,
	output logic kbDataPinOe,
	output logic mouseClockPinOut,
	output logic mouseClockPinOe,
	output logic mouseDataPinOut,
	output logic mouseDataPinOe,
	output logic core_test_input_a,
	output logic core_test_input_b,
	output logic kb_data_readback,
	output logic mouse_data_readback
);

	generate
		if (HOST_ADDR_W < 7) begin : g_chk
			$error("HOST_ADDR_W too small to decode 0x64");
		end
	endgenerate

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire logic [15:0] addrExt;
	wire logic hitData, hitCtl, hostDataWr, hostCmdWr;
	wire logic hostInWr, hostObRd, hostStRd;

	assign addrExt = 16'(hostAddr);
	assign hitData = (addrExt == kbm_pkg::DATA_PORT_ADDR);
	assign hitCtl = (addrExt == kbm_pkg::CTL_PORT_ADDR);
	assign hostDataWr = hostWrStb && hitData;
	assign hostCmdWr = hostWrStb && hitCtl;
	assign hostInWr = hostDataWr || hostCmdWr;
	assign hostObRd = hostRdStb && hitData;
	assign hostStRd = hostRdStb && hitCtl;

	// ----------------------------------------
	// Buffers and status flags
	// ----------------------------------------
	logic [7:0] inBuf_q, outBuf_q, ud_q, port_q;
	logic obf_q, ibf_q, cd_q, enFlags_q;
	wire logic obf_d, ibf_d, cd_d;
	logic [7:0] status;

	// A set in the same cycle as a clear wins, so no event is lost
	assign obf_d = coreObWrStb ? 1'b1 : (hostObRd ? 1'b0 : obf_q);
	// Overwrite of a full buffer simply keeps the flag set
	assign ibf_d = hostInWr ? 1'b1 : (coreIbRdStb ? 1'b0 : ibf_q);
	assign cd_d = hostInWr ? addrExt[kbm_pkg::HOST_ADDR_CD_BIT] : cd_q;

	always_comb begin
		status = ud_q & kbm_pkg::STATUS_UD_MASK;
		status[kbm_pkg::ST_OBF_BIT] = obf_q;
		status[kbm_pkg::ST_IBF_BIT] = ibf_q;
		status[kbm_pkg::ST_CD_BIT] = cd_q;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			obf_q <= 1'b0;
			ibf_q <= 1'b0;
			cd_q <= 1'b0;
			ud_q <= kbm_pkg::STATUS_RESET;
		end else begin
			obf_q <= obf_d;
			ibf_q <= ibf_d;
			cd_q <= cd_d;
			if (coreStatusWrStb) ud_q <= coreStatusWrData;
		end
	end

	// Data buffers clear to 0x00 on reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			inBuf_q <= 8'h00;
			outBuf_q <= 8'h00;
		end else begin
			if (hostInWr) inBuf_q <= hostWrData;
			if (coreObWrStb) outBuf_q <= coreObWrData;
		end
	end

	// ----------------------------------------
	// Flag gating and core port
	// ----------------------------------------
	// Gating stays on once enabled until the next reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			enFlags_q <= 1'b0;
			port_q <= kbm_pkg::PORT_RESET;
		end else begin
			if (coreEnFlagsStb) enFlags_q <= 1'b1;
			if (corePortWrStb) port_q <= corePortWrData;
		end
	end

	wire logic kbIrq_d, mouseIrq_d;

	// Built from next-state flags so the IRQ changes on the same edge as its flag
	assign kbIrq_d = enFlags_q ? (port_q[kbm_pkg::PB_KB_IRQ] && obf_d)
		: port_q[kbm_pkg::PB_KB_IRQ];
	assign mouseIrq_d = enFlags_q ? (port_q[kbm_pkg::PB_MOUSE_IRQ] && !ibf_d)
		: port_q[kbm_pkg::PB_MOUSE_IRQ];

	// ----------------------------------------
	// Power-down control
	// ----------------------------------------
	kbm_pkg::kbm_pwr_t pwr_q, pwr_d;
	wire logic asleep;

	assign asleep = (pwr_q != kbm_pkg::PWR_RUN);

	always_comb begin
		case (pwr_q)
			kbm_pkg::PWR_RUN: begin
				if (coreStopStb) begin
					pwr_d = kbm_pkg::PWR_HARD_DOWN;
				end else if (coreHaltStb) begin
					pwr_d = kbm_pkg::PWR_SOFT_DOWN;
				end else begin
					pwr_d = kbm_pkg::PWR_RUN;
				end
			end
			kbm_pkg::PWR_SOFT_DOWN,
			kbm_pkg::PWR_HARD_DOWN: begin
				pwr_d = hostInWr ? kbm_pkg::PWR_RUN : pwr_q;
			end
			default: begin
				pwr_d = kbm_pkg::PWR_RUN;
			end
		endcase
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	// Reset restarts the core at location 0 by itself; no wake pulse then
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q <= kbm_pkg::PWR_RUN;
			coreWakeCall <= 1'b0;
			coreWakeNext <= 1'b0;
			coreAluClkEn <= 1'b1;
			coreOscEn <= 1'b1;
		end else begin
			pwr_q <= pwr_d;
			coreWakeCall <= asleep && hostInWr && coreIbfIrqEn;
			coreWakeNext <= asleep && hostInWr && !coreIbfIrqEn;
			coreAluClkEn <= (pwr_d == kbm_pkg::PWR_RUN);
			coreOscEn <= (pwr_d != kbm_pkg::PWR_HARD_DOWN);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hostRdData <= 8'h00;
			hostRdValid <= 1'b0;
			keyboard_irq_out <= 1'b0;
			mouse_irq_out <= 1'b0;
			core_input_buffer <= 8'h00;
			coreStatus <= kbm_pkg::STATUS_RESET;
			coreIbfIrq <= 1'b0;
			coreTimerIrq <= 1'b0;
			a20_gate_out <= 1'b0;
		end else begin
			hostRdValid <= hostObRd || hostStRd;
			if (hostObRd) hostRdData <= outBuf_q;
			else if (hostStRd) hostRdData <= status;
			keyboard_irq_out <= kbIrq_d;
			mouse_irq_out <= mouseIrq_d;
			core_input_buffer <= hostInWr ? hostWrData : inBuf_q;
			coreStatus <= status;
			coreIbfIrq <= ibf_d && coreIbfIrqEn;
			coreTimerIrq <= coreTimerOvf;
			a20_gate_out <= port_q[kbm_pkg::PB_A20];
		end
	end

	// ----------------------------------------
	// Open-drain pins
	// ----------------------------------------
	// Pin level is the inverted port bit, so a one pulls the line low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			kbClockPinOe <= 1'b1;
			kbDataPinOe <= 1'b1;
			mouseClockPinOe <= 1'b1;
			mouseDataPinOe <= 1'b1;
		end else begin
			kbClockPinOe <= port_q[kbm_pkg::PB_KB_CLOCK];
			kbDataPinOe <= port_q[kbm_pkg::PB_KB_DATA];
			mouseClockPinOe <= port_q[kbm_pkg::PB_MOUSE_CLOCK];
			mouseDataPinOe <= port_q[kbm_pkg::PB_MOUSE_DATA];
		end
	end

	assign kbClockPinOut = 1'b0;
	assign kbDataPinOut = 1'b0;
	assign mouseClockPinOut = 1'b0;
	assign mouseDataPinOut = 1'b0;

	// Pin readback passes two flops; lines idle high on pull-ups
	logic [3:0] pinSync;

	kbm_sync #(
		.WIDTH(4),
		.RESET_VAL(4'h0)
	) u_pinSync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.asyncIn({mouseDataPinIn, mouseClockPinIn, kbDataPinIn,
			kbClockPinIn}),
		.syncOut(pinSync)
	);

	assign core_test_input_a = pinSync[0];
	assign kb_data_readback = pinSync[1];
	assign core_test_input_b = pinSync[2];
	assign mouse_data_readback = pinSync[3];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	property p_dataWrite;
		hostDataWr && !coreIbRdStb
			|=> ibf_q && !cd_q && inBuf_q == $past(hostWrData);
	endproperty
	a_dataWrite: assert property (p_dataWrite) else
		$error("data write did not set INPUT_BUFFER_FULL with C/D clear");
	property p_cmdWrite;
		hostCmdWr |=> ibf_q && cd_q && status[kbm_pkg::ST_CD_BIT];
	endproperty
	a_cmdWrite: assert property (p_cmdWrite) else
		$error("command write did not set C/D");
	property p_obfSet;
		coreObWrStb |=> obf_q && outBuf_q == $past(coreObWrData);
	endproperty
	a_obfSet: assert property (p_obfSet) else
		$error("core output write did not set OUTPUT_BUFFER_FULL");
	property p_obfClear;
		hostObRd && !coreObWrStb |=> !obf_q;
	endproperty
	a_obfClear: assert property (p_obfClear) else
		$error("host output read did not clear OUTPUT_BUFFER_FULL");
	property p_ibfClear;
		coreIbRdStb && !hostInWr |=> !ibf_q && !coreIbfIrq;
	endproperty
	a_ibfClear: assert property (p_ibfClear) else
		$error("core read did not clear INPUT_BUFFER_FULL and its interrupt");
	property p_kbIrqGate;
		enFlags_q && !port_q[kbm_pkg::PB_KB_IRQ] |=> !keyboard_irq_out;
	endproperty
	a_kbIrqGate: assert property (p_kbIrqGate) else
		$error("keyboard IRQ not forced low by port bit");
	property p_kbIrqRead;
		enFlags_q && hostObRd && !coreObWrStb |=> !keyboard_irq_out;
	endproperty
	a_kbIrqRead: assert property (p_kbIrqRead) else
		$error("host read did not clear keyboard IRQ");
	property p_mouseIrq;
		enFlags_q && port_q[kbm_pkg::PB_MOUSE_IRQ] && ibf_d
			|=> !mouse_irq_out;
	endproperty
	a_mouseIrq: assert property (p_mouseIrq) else
		$error("mouse IRQ high while input buffer full");
	property p_haltWake;
		pwr_q == kbm_pkg::PWR_SOFT_DOWN && !hostInWr |=> !coreAluClkEn;
	endproperty
	a_haltWake: assert property (p_haltWake) else
		$error("ALU clock running during soft power-down");
	property p_stopWake;
		asleep && hostInWr |=> coreAluClkEn && coreOscEn
			&& (coreWakeCall != coreWakeNext);
	endproperty
	a_stopWake: assert property (p_stopWake) else
		$error("host write did not wake the core");
	property p_pinDrive;
		corePortWrStb |=> ##1 kbClockPinOe == $past(corePortWrData[6], 2);
	endproperty
	a_pinDrive: assert property (p_pinDrive) else
		$error("keyboard clock pin does not follow its port bit");

endmodule
`default_nettype wire

// >>> bench/kbm_host_model.sv
// Host CPU model: I/O write and read cycles toward the mailbox.
// Assumes one-cycle strobes sampled on the rising edge of clk_sys.
`timescale 1ns/10ps
`default_nettype none
module kbm_host_model (
	input wire logic clk_sys,
	output logic hostWrStb,
	output logic hostRdStb,
	output logic [15:0] hostAddr,
	output logic [7:0] hostWrData,
	input wire logic [7:0] hostRdData,
	input wire logic hostRdValid
);
	initial begin
		hostWrStb = 1'b0;
		hostRdStb = 1'b0;
		hostAddr = 16'hffff;
		hostWrData = 8'hff;
	end

	// Idle bus shows the inverted last value, so stale bytes never match
	task automatic hostWrite(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		hostWrStb <= 1'b1;
		hostAddr <= a;
		hostWrData <= d;
		@(posedge clk_sys);
		hostWrStb <= 1'b0;
		hostAddr <= ~a;
		hostWrData <= ~d;
		#1;
	endtask

	task automatic hostRead(input logic [15:0] a, output logic [7:0] d,
		output logic v);
		@(posedge clk_sys);
		hostRdStb <= 1'b1;
		hostAddr <= a;
		@(posedge clk_sys);
		hostRdStb <= 1'b0;
		hostAddr <= ~a;
		#1;
		v = hostRdValid;
		d = hostRdData;
	endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench of the keyboard-controller host mailbox.
// Assumes pins have pull-ups; extLow models a device pulling a pin low.
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam int IB_RD = 0;
	localparam int OB_WR = 1;
	localparam int ST_WR = 2;
	localparam int PORT = 3;
	localparam int EN = 4;
	localparam int HALT = 5;
	localparam int STOP = 6;
	logic clk_sys, rst_n, hostWrStb, hostRdStb, hostRdValid;
	logic keyboard_irq_out, mouse_irq_out, coreIbRdStb, coreObWrStb;
	logic coreStatusWrStb, corePortWrStb, coreEnFlagsStb, coreHaltStb;
	logic coreStopStb, coreIbfIrqEn, coreTimerOvf, coreIbfIrq, coreTimerIrq;
	logic coreAluClkEn, coreOscEn, coreWakeCall, coreWakeNext, a20_gate_out;
	logic kbClockPinOut, kbClockPinOe, kbDataPinOut, kbDataPinOe;
	logic mouseClockPinOut, mouseClockPinOe, mouseDataPinOut, mouseDataPinOe;
	logic core_test_input_a, core_test_input_b, kb_data_readback;
	logic mouse_data_readback;
	logic [15:0] hostAddr;
	logic [7:0] hostWrData, hostRdData, coreObWrData, coreStatusWrData;
	logic [7:0] corePortWrData, core_input_buffer, coreStatus;
	logic [3:0] extLow;
	logic [3:0] callCnt = 4'h0;
	logic [3:0] nextCnt = 4'h0;
	wire logic [3:0] pinLvl;
	int errors = 0;
	int samplesChecked = 0;
	int cycles = 0;

	// ----------------------------------------
	// Open-drain pins: low if driven or pulled, else pull-up
	// ----------------------------------------
	assign pinLvl = ~({mouseDataPinOe, mouseClockPinOe, kbDataPinOe,
		kbClockPinOe} | extLow);

	kbm_host_model hostM (.clk_sys, .hostWrStb, .hostRdStb, .hostAddr,
		.hostWrData, .hostRdData, .hostRdValid);

	kbm_host_mailbox DUT (.clk_sys, .rst_n, .hostWrStb, .hostRdStb,
		.hostAddr, .hostWrData, .hostRdData, .hostRdValid,
		.keyboard_irq_out, .mouse_irq_out, .coreIbRdStb, .coreObWrStb,
		.coreObWrData, .coreStatusWrStb, .coreStatusWrData, .corePortWrStb,
		.corePortWrData, .coreEnFlagsStb, .coreHaltStb, .coreStopStb,
		.coreIbfIrqEn, .coreTimerOvf, .core_input_buffer, .coreStatus,
		.coreIbfIrq, .coreTimerIrq, .coreAluClkEn, .coreOscEn, .coreWakeCall,
		.coreWakeNext, .a20_gate_out, .kbClockPinIn(pinLvl[0]),
		.kbDataPinIn(pinLvl[1]), .mouseClockPinIn(pinLvl[2]),
		.mouseDataPinIn(pinLvl[3]), .kbClockPinOut, .kbClockPinOe,
		.kbDataPinOut, .kbDataPinOe, .mouseClockPinOut, .mouseClockPinOe,
		.mouseDataPinOut, .mouseDataPinOe, .core_test_input_a,
		.core_test_input_b, .kb_data_readback, .mouse_data_readback);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tally_and_finish();
		if (errors == 0 && samplesChecked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic waitCyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// One core strobe for one cycle; bit order matches the which codes
	task automatic corePulse(input int which, input logic [7:0] d);
		@(posedge clk_sys);
		{coreStopStb, coreHaltStb, coreEnFlagsStb, corePortWrStb,
			coreStatusWrStb, coreObWrStb, coreIbRdStb} <= 7'h01 << which;
		coreObWrData <= d;
		coreStatusWrData <= d;
		corePortWrData <= d;
		@(posedge clk_sys);
		{coreStopStb, coreHaltStb, coreEnFlagsStb, corePortWrStb,
			coreStatusWrStb, coreObWrStb, coreIbRdStb} <= 7'h00;
		#1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic tReset();
		logic [7:0] d;
		logic v;
		check({kbClockPinOe, kbDataPinOe, mouseClockPinOe, mouseDataPinOe},
			4'hf);
		check({keyboard_irq_out, mouse_irq_out, a20_gate_out}, 3'h0);
		hostM.hostRead(16'h0064, d, v);
		check({v, d}, 9'h100);
	endtask

	task automatic tMailbox();
		logic [7:0] d;
		logic v;
		hostM.hostWrite(16'h0060, 8'h11);
		check(core_input_buffer, 8'h11);
		waitCyc(1);
		check(coreStatus, 8'h02);
		check(coreIbfIrq, 1'b1);
		hostM.hostWrite(16'h0064, 8'h22);
		hostM.hostWrite(16'h0061, 8'h33);
		hostM.hostRead(16'h0064, d, v);
		check(d, 8'h0a);
		check(core_input_buffer, 8'h22);
		hostM.hostRead(16'h0061, d, v);
		check(v, 1'b0);
		corePulse(IB_RD, 8'h00);
		waitCyc(1);
		check({coreIbfIrq, coreStatus}, 9'h008);
		corePulse(ST_WR, 8'hff);
		hostM.hostRead(16'h0064, d, v);
		check(d, 8'hfc);
		corePulse(OB_WR, 8'ha5);
		hostM.hostRead(16'h0060, d, v);
		check({v, d}, 9'h1a5);
		hostM.hostRead(16'h0064, d, v);
		check(d, 8'hfc);
	endtask

	task automatic tIrqUngated();
		logic [7:0] d;
		logic v;
		corePulse(OB_WR, 8'h77);
		corePulse(PORT, 8'h00);
		waitCyc(2);
		check({keyboard_irq_out, mouse_irq_out}, 2'b00);
		corePulse(PORT, 8'h10);
		waitCyc(2);
		check({keyboard_irq_out, mouse_irq_out}, 2'b10);
		// Without gating, software clears the keyboard IRQ itself
		corePulse(PORT, 8'h20);
		waitCyc(2);
		check({keyboard_irq_out, mouse_irq_out}, 2'b01);
		hostM.hostRead(16'h0060, d, v);
		check({v, d}, 9'h177);
	endtask

	task automatic tPins();
		corePulse(PORT, 8'h02);
		waitCyc(4);
		check({a20_gate_out, kbClockPinOe, kbDataPinOe, mouseClockPinOe,
			mouseDataPinOe}, 5'h10);
		check({core_test_input_a, kb_data_readback, core_test_input_b,
			mouse_data_readback}, 4'hf);
		@(posedge clk_sys);
		extLow <= 4'b0101;
		waitCyc(3);
		check({core_test_input_a, kb_data_readback, core_test_input_b,
			mouse_data_readback}, 4'h5);
		@(posedge clk_sys);
		extLow <= 4'b0000;
		corePulse(PORT, 8'hc0);
		waitCyc(4);
		check({a20_gate_out, kbClockPinOe, kbDataPinOe, mouseClockPinOe,
			mouseDataPinOe}, 5'h0c);
		check({core_test_input_a, kb_data_readback, core_test_input_b,
			mouse_data_readback}, 4'h3);
		check({kbClockPinOut, kbDataPinOut, mouseClockPinOut,
			mouseDataPinOut}, 4'h0);
	endtask

	task automatic tIrqGated();
		logic [7:0] d;
		logic v;
		corePulse(EN, 8'h00);
		corePulse(PORT, 8'h30);
		waitCyc(2);
		check({keyboard_irq_out, mouse_irq_out}, 2'b01);
		corePulse(OB_WR, 8'h3c);
		check(keyboard_irq_out, 1'b1);
		hostM.hostRead(16'h0060, d, v);
		check({keyboard_irq_out, d}, 9'h03c);
		hostM.hostWrite(16'h0060, 8'h44);
		waitCyc(1);
		check(mouse_irq_out, 1'b0);
		corePulse(PORT, 8'h00);
		corePulse(OB_WR, 8'h55);
		waitCyc(2);
		check(keyboard_irq_out, 1'b0);
	endtask

	task automatic tTimerPower();
		@(posedge clk_sys);
		coreTimerOvf <= 1'b1;
		waitCyc(2);
		check(coreTimerIrq, 1'b1);
		@(posedge clk_sys);
		coreTimerOvf <= 1'b0;
		corePulse(HALT, 8'h00);
		check({coreTimerIrq, coreAluClkEn, coreOscEn}, 3'b001);
		hostM.hostWrite(16'h0060, 8'h01);
		waitCyc(1);
		check({coreAluClkEn, coreOscEn, callCnt, nextCnt}, 10'h310);
		@(posedge clk_sys);
		coreIbfIrqEn <= 1'b0;
		corePulse(STOP, 8'h00);
		check({coreAluClkEn, coreOscEn}, 2'b00);
		hostM.hostWrite(16'h0064, 8'h02);
		waitCyc(1);
		check({coreAluClkEn, coreOscEn, callCnt, nextCnt}, 10'h311);
		corePulse(HALT, 8'h00);
		// Held long enough for the oscillator to settle
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (kbm_pkg::RESET_MIN_CYCLES) @(posedge clk_sys);
		check(coreAluClkEn, 1'b1);
		rst_n <= 1'b1;
		waitCyc(2);
		check({coreStatus, callCnt, nextCnt}, 16'h0011);
		check({kbClockPinOe, kbDataPinOe, mouseClockPinOe, mouseDataPinOe},
			4'hf);
	endtask

	// ----------------------------------------
	// Clock, timeout and main sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (coreWakeCall === 1'b1) callCnt <= callCnt + 4'h1;
		if (coreWakeNext === 1'b1) nextCnt <= nextCnt + 4'h1;
		if (cycles == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	initial begin
		rst_n = 1'b0;
		{coreStopStb, coreHaltStb, coreEnFlagsStb, corePortWrStb,
			coreStatusWrStb, coreObWrStb, coreIbRdStb} = 7'h00;
		coreObWrData = 8'h00;
		coreStatusWrData = 8'h00;
		corePortWrData = 8'h00;
		coreIbfIrqEn = 1'b1;
		coreTimerOvf = 1'b0;
		extLow = 4'h0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		tReset();
		tMailbox();
		tIrqUngated();
		tPins();
		tIrqGated();
		tTimerPower();
		tally_and_finish();
	end
endmodule
`default_nettype wire
